// ### core/usx_defs.svh
/*
  Offsets, field positions, reset values and code words for the USXGMII
  coding sublayer with transmit rate adaptation.
  Assumes it is included by bare name from files that use the macros.
*/
`ifndef USX_DEFS_SVH
`define USX_DEFS_SVH

// register byte offsets on the 32-bit bus
`define USX_OFS_SD_CFG 8'h00
`define USX_OFS_LOCK_STAT 8'h04
`define USX_OFS_RST_CTRL 8'h08
`define USX_OFS_RADAPT_CFG 8'h0C
`define USX_OFS_IRQ_STAT 8'h10
`define USX_OFS_IRQ_MASK 8'h14
`define USX_OFS_SPEED 8'h18

// signal_detect_config fields
`define USX_SIGNAL_DETECT_POLARITY_BIT 0
`define USX_SD_USE_BIT 1
// pcs_lock_status fields
`define USX_LOCK_BIT 0
`define USX_SIGDET_BIT 1
// device_reset_control fields
`define USX_OW_DIS_BIT 0
// tx_rate_adapt_config fields
`define USX_MIN_GAP_LSB 0
`define USX_ADD_LSB 4
`define USX_DROP_LSB 12
`define USX_LF_DIS_BIT 20

// reset values
`define USX_MIN_GAP_RST 2'h1
`define USX_ADD_RST 5'h04
`define USX_DROP_RST 5'h08

// interrupt event bits
`define USX_EV_SIG_LOST 0
`define USX_EV_LOCK_LOST 1
`define USX_EV_ADD 2
`define USX_EV_DROP 3
`define USX_EV_W 4

// transmit FIFO shape, 72-bit words
`define USX_FIFO_DEPTH 16
`define USX_LVL_W 5

// XGMII code words
`define USX_IDLE_BYTE 8'h07
`define USX_TERM_BYTE 8'hFD
`define USX_SEQ_BYTE 8'h9C
`define USX_LF_CODE 8'h01
`define USX_RF_CODE 8'h02
`define USX_IDLE_WORD 64'h0707070707070707
`define USX_LF_WORD 64'h0100009C0100009C
`define USX_LF_CTL 8'h11
`define USX_ALL_CTL 8'hFF

`endif

// ### core/usx_pkg.sv
/*
  Types shared by the USXGMII coding sublayer files.
  Assumes nothing of its surroundings.
*/
package usx_pkg;
  // port speed selections, replication follows from them
  typedef enum logic [2:0] {SPD_10G, SPD_5G, SPD_2G5, SPD_1G, SPD_100M, SPD_10M} spd_e;
  typedef logic [71:0] xword_t;
  typedef logic [9:0] rep_t;
endpackage

// ### core/usx_rate_fifo.sv
/*
  Flip-flop FIFO of 72-bit XGMII words for transmit rate adaptation.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usx_defs.svh"
module usx_rate_fifo
  import usx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input var xword_t wdata_in,
  input wire logic pop_in,
  output var xword_t rdata_out,
  output logic [`USX_LVL_W-1:0] level_out,
  output logic empty_out,
  output logic full_out
);
  xword_t mem_q [`USX_FIFO_DEPTH];
  logic [`USX_LVL_W-2:0] wr_q;
  logic [`USX_LVL_W-2:0] rd_q;
  logic [`USX_LVL_W-1:0] lvl_q;

  // storage, written at the write index
  always_ff @(posedge clk_in)
  begin
    if (push_in)
      mem_q[wr_q] <= wdata_in;
  end

  // pointers and fill level move together
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      if (push_in)
        wr_q <= wr_q + 1'b1;
      if (pop_in)
        rd_q <= rd_q + 1'b1;
      if (push_in && !pop_in)
        lvl_q <= lvl_q + 1'b1;
      else if (pop_in && !push_in)
        lvl_q <= lvl_q - 1'b1;
    end
  end

  assign rdata_out = mem_q[rd_q];
  assign level_out = lvl_q;
  assign empty_out = (lvl_q == '0);
  assign full_out = (lvl_q == `USX_LVL_W'(`USX_FIFO_DEPTH));
endmodule
`default_nettype wire

// ### core/usxgmii_pcs_rate_adapt.sv
/*
  USXGMII coding sublayer for one switch port: signal-detect qualification,
  block-lock status, receive replicator with fault overwrite, transmit
  rate adaptation with add/drop thresholds and local fault generation,
  APB registers and one level interrupt.
  Assumes one 25 MHz clock, synchronous active-high reset, and that the
  block-lock level and signal-detect pin are synchronous to that clock.
*/
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "usx_defs.svh"
// Operation
// - With signal-detect use at 0 the pin is ignored and a signal always counts as present.
// - With signal-detect use at 1 the pin decides whether a signal is present.
// - With signal-detect use at 1, a signal counts as detected only when the pin level equals the programmed polarity.
// - While no signal is detected, auto-negotiation is held in restart.
// - The lock flag reads 1 in block lock and 0 otherwise.
// - At reduced speed only the first word of each replication group is sampled.
// - Unless overwrite is disabled, a fault ordered set in a skipped replica replaces the next word.
// - Idles are added against a programmable add level counted in 72-bit words.
// - Idles are dropped against a programmable drop level counted in 72-bit words.
// - Local fault is sent while not aligned unless local fault generation is disabled.
// - Speeds 10, 100, 1000, 2500, 5000 and 10000 Mbps are supported, full duplex only.
module usxgmii_pcs_rate_adapt
  import usx_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic SIGNAL_DETECT_IN,
  input wire logic RX_BLOCK_LOCK_IN,
  output logic ANEG_RESTART_OUT,
  input wire logic RX_VALID_IN,
  input wire logic [63:0] RXD_IN,
  input wire logic [7:0] RXC_IN,
  output logic RX_VALID_OUT,
  output logic [63:0] RXD_OUT,
  output logic [7:0] RXC_OUT,
  input wire logic TX_VALID_IN,
  input wire logic [63:0] TXD_IN,
  input wire logic [7:0] TXC_IN,
  output logic TX_READY_OUT,
  input wire logic LINE_READY_IN,
  output logic [63:0] TXD_OUT,
  output logic [7:0] TXC_OUT,
  output logic IRQ_OUT
);
  // fault ordered set in one 32-bit half of a word
  function automatic logic half_fault(input logic [31:0] d, input logic c);
    half_fault = c && d[7:0] == `USX_SEQ_BYTE && d[23:8] == 16'h0000
      && (d[31:24] == `USX_LF_CODE || d[31:24] == `USX_RF_CODE);
  endfunction

  // word made only of idles or only of fault ordered sets
  function automatic logic gap_word(input logic [63:0] d, input logic [7:0] c);
    gap_word = (c == `USX_ALL_CTL && d == `USX_IDLE_WORD)
      || (half_fault(d[31:0], c[0]) && half_fault(d[63:32], c[4]));
  endfunction

  // replication group size minus one for each speed
  function automatic rep_t rep_last(input spd_e s);
    case (s)
      SPD_5G: rep_last = 10'd1;
      SPD_2G5: rep_last = 10'd3;
      SPD_1G: rep_last = 10'd9;
      SPD_100M: rep_last = 10'd99;
      SPD_10M: rep_last = 10'd999;
      default: rep_last = 10'd0;
    endcase
  endfunction

  logic signal_detect_polarity_q;
  logic sd_use_q;
  logic ow_dis_q;
  logic lf_dis_q;
  logic [1:0] min_gap_q;
  logic [`USX_LVL_W-1:0] add_lvl_q;
  logic [`USX_LVL_W-1:0] drop_lvl_q;
  spd_e speed_q;
  logic [`USX_EV_W-1:0] irq_stat_q;
  logic [`USX_EV_W-1:0] irq_mask_q;
  logic [`USX_EV_W-1:0] events;
  logic sig_det_q;
  logic lock_q;
  logic access;
  logic wr_now;
  logic [31:0] rd_data;
  logic rd_err;

  // apb: one wait state, writes land on the edge that sees pready high
  assign access = PSEL_IN && PENABLE_IN;
  assign wr_now = access && PREADY_OUT && PWRITE_IN;

  // read mux and unmapped-address decode
  always_comb
  begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    if (PADDR_IN == `USX_OFS_SD_CFG)
      rd_data = {30'h0, sd_use_q, signal_detect_polarity_q};
    else if (PADDR_IN == `USX_OFS_LOCK_STAT)
      rd_data = {30'h0, sig_det_q, lock_q};
    else if (PADDR_IN == `USX_OFS_RST_CTRL)
      rd_data = {31'h0, ow_dis_q};
    else if (PADDR_IN == `USX_OFS_RADAPT_CFG)
      rd_data = {11'h0, lf_dis_q, 3'h0, drop_lvl_q, 3'h0, add_lvl_q, 2'h0, min_gap_q};
    else if (PADDR_IN == `USX_OFS_IRQ_STAT)
      rd_data = {28'h0, irq_stat_q};
    else if (PADDR_IN == `USX_OFS_IRQ_MASK)
      rd_data = {28'h0, irq_mask_q};
    else if (PADDR_IN == `USX_OFS_SPEED)
      rd_data = {29'h0, speed_q};
    else
      rd_err = 1'b1;
  end

  // bus answer flops
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0;
    end
    else
    begin
      PREADY_OUT <= access && !PREADY_OUT;
      PSLVERR_OUT <= access && !PREADY_OUT && rd_err;
      if (access && !PREADY_OUT && !PWRITE_IN)
        PRDATA_OUT <= rd_data;
    end
  end

  // configuration registers; rate-adapt resets to the advised values
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      signal_detect_polarity_q <= 1'b1;
      sd_use_q <= 1'b0;
      ow_dis_q <= 1'b0;
      lf_dis_q <= 1'b0;
      min_gap_q <= `USX_MIN_GAP_RST;
      add_lvl_q <= `USX_ADD_RST;
      drop_lvl_q <= `USX_DROP_RST;
      speed_q <= SPD_10G;
      irq_mask_q <= '0;
    end
    else if (wr_now)
    begin
      if (PADDR_IN == `USX_OFS_SD_CFG)
      begin
        signal_detect_polarity_q <= PWDATA_IN[`USX_SIGNAL_DETECT_POLARITY_BIT];
        sd_use_q <= PWDATA_IN[`USX_SD_USE_BIT];
      end
      else if (PADDR_IN == `USX_OFS_RST_CTRL)
        ow_dis_q <= PWDATA_IN[`USX_OW_DIS_BIT];
      else if (PADDR_IN == `USX_OFS_RADAPT_CFG)
      begin
        min_gap_q <= PWDATA_IN[`USX_MIN_GAP_LSB +: 2];
        add_lvl_q <= PWDATA_IN[`USX_ADD_LSB +: `USX_LVL_W];
        drop_lvl_q <= PWDATA_IN[`USX_DROP_LSB +: `USX_LVL_W];
        lf_dis_q <= PWDATA_IN[`USX_LF_DIS_BIT];
      end
      else if (PADDR_IN == `USX_OFS_IRQ_MASK)
        irq_mask_q <= PWDATA_IN[`USX_EV_W-1:0];
      else if (PADDR_IN == `USX_OFS_SPEED && PWDATA_IN[2:0] <= 3'(SPD_10M))
        speed_q <= spd_e'(PWDATA_IN[2:0]);
    end
  end

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      irq_stat_q <= '0;
    else if (wr_now && PADDR_IN == `USX_OFS_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~PWDATA_IN[`USX_EV_W-1:0]) | events;
    else
      irq_stat_q <= irq_stat_q | events;
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= |(irq_stat_q & irq_mask_q);
  end

  // signal qualification; pin ignored when use is off
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      sig_det_q <= 1'b0;
      lock_q <= 1'b0;
      ANEG_RESTART_OUT <= 1'b1;
    end
    else
    begin
      sig_det_q <= !sd_use_q || (SIGNAL_DETECT_IN == signal_detect_polarity_q);
      lock_q <= RX_BLOCK_LOCK_IN;
      ANEG_RESTART_OUT <= !sig_det_q;
    end
  end

  sd_ignored_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    !sd_use_q && !$past(RST_IN) |=> sig_det_q)
    else $error("signal detect not forced while unused");
  sd_polarity_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    sd_use_q && !$past(RST_IN) |=> sig_det_q == ($past(SIGNAL_DETECT_IN) == $past(signal_detect_polarity_q)))
    else $error("signal detect does not follow pin and polarity");
  sd_mismatch_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    sd_use_q && SIGNAL_DETECT_IN != signal_detect_polarity_q |=> !sig_det_q)
    else $error("signal seen with wrong polarity");
  aneg_restart_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    !sig_det_q |=> ANEG_RESTART_OUT)
    else $error("no restart while signal lost");
  lock_flag_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    RX_BLOCK_LOCK_IN ##1 RX_BLOCK_LOCK_IN |-> lock_q)
    else $error("lock flag low in block lock");

  // receive replicator
  rep_t rep_cnt_q;
  logic fault_pend_q;
  logic [63:0] fault_d_q;
  logic [7:0] fault_c_q;
  logic replica_fault;

  assign replica_fault = half_fault(RXD_IN[31:0], RXC_IN[0])
    || half_fault(RXD_IN[63:32], RXC_IN[4]);

  // sample first word of each group; skipped fault sets overwrite the next one
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      rep_cnt_q <= '0;
      fault_pend_q <= 1'b0;
      fault_d_q <= 64'h0;
      fault_c_q <= 8'h00;
      RX_VALID_OUT <= 1'b0;
      RXD_OUT <= `USX_IDLE_WORD;
      RXC_OUT <= `USX_ALL_CTL;
    end
    else
    begin
      RX_VALID_OUT <= 1'b0;
      if (ow_dis_q)
        fault_pend_q <= 1'b0;
      if (RX_VALID_IN)
      begin
        if (rep_cnt_q == '0)
        begin
          RX_VALID_OUT <= 1'b1;
          RXD_OUT <= (fault_pend_q && !ow_dis_q) ? fault_d_q : RXD_IN;
          RXC_OUT <= (fault_pend_q && !ow_dis_q) ? fault_c_q : RXC_IN;
          fault_pend_q <= 1'b0;
          rep_cnt_q <= rep_last(speed_q);
        end
        else
        begin
          rep_cnt_q <= rep_cnt_q - 1'b1;
          if (replica_fault && !ow_dis_q)
          begin
            fault_pend_q <= 1'b1;
            fault_d_q <= RXD_IN;
            fault_c_q <= RXC_IN;
          end
        end
      end
    end
  end

  first_sample_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    RX_VALID_OUT |-> $past(rep_cnt_q) == '0 && $past(RX_VALID_IN))
    else $error("replica word was sampled");
  overwrite_off_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ow_dis_q ##1 ow_dis_q |-> !fault_pend_q)
    else $error("fault overwrite armed while disabled");

  // transmit rate adaptation
  xword_t fifo_head;
  logic [`USX_LVL_W-1:0] fifo_lvl;
  logic fifo_empty;
  logic fifo_push;
  logic fifo_pop;
  logic in_gap;
  logic in_term;
  logic drop_now;
  logic add_now;
  logic lf_active;
  logic last_gap_q;
  logic [1:0] gap_cnt_q;
  logic [1:0] gap_inc;

  assign in_gap = gap_word(TXD_IN, TXC_IN);
  assign in_term = |(TXC_IN & {TXD_IN[63:56] == `USX_TERM_BYTE, TXD_IN[55:48] == `USX_TERM_BYTE,
    TXD_IN[47:40] == `USX_TERM_BYTE, TXD_IN[39:32] == `USX_TERM_BYTE,
    TXD_IN[31:24] == `USX_TERM_BYTE, TXD_IN[23:16] == `USX_TERM_BYTE,
    TXD_IN[15:8] == `USX_TERM_BYTE, TXD_IN[7:0] == `USX_TERM_BYTE});
  // drop only gap words above the drop level, once the minimum gap is kept
  assign drop_now = TX_VALID_IN && TX_READY_OUT && in_gap
    && fifo_lvl > drop_lvl_q && gap_cnt_q >= min_gap_q;
  assign fifo_push = TX_VALID_IN && TX_READY_OUT && !drop_now;
  assign lf_active = !lock_q && !lf_dis_q;
  // add an idle between frames below the add level, or on underrun
  assign add_now = LINE_READY_IN && !lf_active
    && (fifo_empty || (fifo_lvl < add_lvl_q && last_gap_q));
  assign fifo_pop = LINE_READY_IN && !lf_active && !add_now;
  // a gap word carries two 4-byte transactions
  assign gap_inc = (gap_cnt_q == 2'd3) ? 2'd3 : ((gap_cnt_q == 2'd2) ? 2'd3 : gap_cnt_q + 2'd2);
  assign events = {drop_now, add_now, lock_q && !RX_BLOCK_LOCK_IN,
    sig_det_q && ANEG_RESTART_OUT == 1'b0 && !(!sd_use_q || (SIGNAL_DETECT_IN == signal_detect_polarity_q))};

  usx_rate_fifo u_usx_rate_fifo (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .push_in(fifo_push),
    .wdata_in({TXC_IN, TXD_IN}),
    .pop_in(fifo_pop),
    .rdata_out(fifo_head),
    .level_out(fifo_lvl),
    .empty_out(fifo_empty),
    .full_out()
  );

  // gap length kept since the last terminate, in transactions, saturating at 3
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      gap_cnt_q <= 2'd3;
    else if (fifo_push)
    begin
      if (in_term)
        gap_cnt_q <= 2'd0;
      else if (in_gap)
        gap_cnt_q <= gap_inc;
      else
        gap_cnt_q <= 2'd0;
    end
  end

  // mac-side ready leaves room for one more word next cycle
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      TX_READY_OUT <= 1'b0;
    else
      TX_READY_OUT <= fifo_lvl <= `USX_LVL_W'(`USX_FIFO_DEPTH - 2);
  end

  // line-side word: local fault, added idle or the fifo head
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      TXD_OUT <= `USX_LF_WORD;
      TXC_OUT <= `USX_LF_CTL;
      last_gap_q <= 1'b1;
    end
    else if (LINE_READY_IN)
    begin
      if (lf_active)
      begin
        TXD_OUT <= `USX_LF_WORD;
        TXC_OUT <= `USX_LF_CTL;
        last_gap_q <= 1'b1;
      end
      else if (add_now)
      begin
        TXD_OUT <= `USX_IDLE_WORD;
        TXC_OUT <= `USX_ALL_CTL;
        last_gap_q <= 1'b1;
      end
      else
      begin
        TXD_OUT <= fifo_head[63:0];
        TXC_OUT <= fifo_head[71:64];
        last_gap_q <= gap_word(fifo_head[63:0], fifo_head[71:64]);
      end
    end
  end

  min_gap_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    drop_now |-> gap_cnt_q >= min_gap_q && gap_cnt_q != 2'd0)
    else $error("drop cut into minimum gap");
  add_idle_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    LINE_READY_IN && !lf_active && fifo_lvl < add_lvl_q && last_gap_q
    |=> TXD_OUT == `USX_IDLE_WORD && TXC_OUT == `USX_ALL_CTL)
    else $error("no idle added below add level");
  drop_level_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    drop_now |-> fifo_lvl > drop_lvl_q && !fifo_push)
    else $error("word dropped at or below drop level");
  lf_send_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    LINE_READY_IN && !lock_q && !lf_dis_q
    |=> TXD_OUT == `USX_LF_WORD && TXC_OUT == `USX_LF_CTL)
    else $error("local fault missing while unaligned");
endmodule
`default_nettype wire

// ### tb/usx_line_partner.sv
/*
  Line-side partner: gives line ready for transmit words and sends receive words.
  Assumes the bench moves stall and go just after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module usx_line_partner (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic go_in,
  input wire logic [71:0] word_in,
  output logic line_ready_out,
  output logic rx_valid_out,
  output logic [71:0] rx_word_out
);
  // the line takes a word each cycle unless the bench holds it off
  assign line_ready_out = !stall_in;
  // start quiet so the receive inputs are never unknown
  initial
  begin
    rx_valid_out = 1'b0;
    rx_word_out = '0;
  end
  // between words the lane shows the inverse, so stale data cannot pass as valid
  always @(posedge clk_in)
  begin
    rx_valid_out <= go_in;
    rx_word_out <= go_in ? word_in : ~rx_word_out;
  end
endmodule
`default_nettype wire

// ### tb/usxgmii_pcs_rate_adapt_tb.sv
/*
  Bench for the coding sublayer: registers, signal detect, lock, replicator,
  transmit rate adaptation and interrupt.
  Assumes the design files and the line partner are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usx_defs.svh"
module usxgmii_pcs_rate_adapt_tb;
  import usx_pkg::*;
  localparam logic [71:0] IDL = {`USX_ALL_CTL, `USX_IDLE_WORD};
  localparam logic [71:0] LFW = {`USX_LF_CTL, `USX_LF_WORD};
  localparam logic [71:0] TRM = {8'hFF, 56'h07070707070707, `USX_TERM_BYTE};
  logic clk, rst, psel, pen, pwr, sd, lock, txv, stall, go, rerr;
  logic rdy, err, rxv_in, rxv, txr, lrdy, aneg, irq;
  logic [7:0] pa, rxc, txc;
  logic [31:0] pwd, prd, rdat;
  logic [63:0] rxd, txd;
  logic [71:0] txw, gow, rxw, last;
  logic [71:0] q[$];
  int mismatches, check_count, cyc, vcnt;
  int grp[6] = '{1, 2, 4, 10, 100, 1000};
  // use, polarity, pin, expected restart, expected detect
  logic [4:0] sdr[8] = '{5'h01, 5'h05, 5'h09, 5'h0D, 5'h11, 5'h16, 5'h1A, 5'h1D};
  // refused flag, address, expected read value
  logic [40:0] rrow[4] = '{{1'b0, `USX_OFS_SD_CFG, 32'h1},
    {1'b0, `USX_OFS_RADAPT_CFG, 32'h8041}, {1'b0, `USX_OFS_RST_CTRL, 32'h0},
    {1'b1, 8'h1C, 32'h0}};
  // address, write data, expected interrupt level
  logic [12:0] irw[4] = '{{`USX_OFS_IRQ_MASK, 4'hF, 1'b1}, {`USX_OFS_IRQ_MASK, 4'h0, 1'b0},
    {`USX_OFS_IRQ_MASK, 4'hF, 1'b1}, {`USX_OFS_IRQ_STAT, 4'hF, 1'b0}};
  logic [71:0] ow[8] = '{72'h1, LFW, IDL, IDL, 72'h2, 72'h2, 72'h2, 72'h2};

  usxgmii_pcs_rate_adapt u_usxgmii_pcs_rate_adapt (.MCLK_IN(clk), .RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .SIGNAL_DETECT_IN(sd),
    .RX_BLOCK_LOCK_IN(lock), .ANEG_RESTART_OUT(aneg), .RX_VALID_IN(rxv_in),
    .RXD_IN(rxw[63:0]), .RXC_IN(rxw[71:64]), .RX_VALID_OUT(rxv), .RXD_OUT(rxd),
    .RXC_OUT(rxc), .TX_VALID_IN(txv), .TXD_IN(txw[63:0]), .TXC_IN(txw[71:64]),
    .TX_READY_OUT(txr), .LINE_READY_IN(lrdy), .TXD_OUT(txd), .TXC_OUT(txc), .IRQ_OUT(irq));
  usx_line_partner u_usx_line_partner (.clk_in(clk), .stall_in(stall), .go_in(go),
    .word_in(gow), .line_ready_out(lrdy), .rx_valid_out(rxv_in), .rx_word_out(rxw));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // settled view: count receive samples, log each new line word
  always @(negedge clk)
  begin
    if (rxv === 1'b1)
      vcnt++;
    if ({txc, txd} !== last)
    begin
      last = {txc, txd};
      q.push_back(last);
    end
  end
  // a hang anywhere ends the run as a failure
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [71:0] s, input logic [71:0] x);
    check_count++;
    if (s !== x)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // apb transfer; ready, read data and error are taken at the rising edge that sees ready
  // high, and only the bench watchdog ends a wait that never sees it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rdat = prd;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask
  // word held until the rising edge that sees ready high takes it
  task automatic push(input logic [71:0] w);
    txv <= 1'b1;
    txw <= w;
    do @(posedge clk); while (txr !== 1'b1);
    txv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rxs(input logic [71:0] w);
    go <= 1'b1;
    gow <= w;
    @(posedge clk);
  endtask
  // expected line order: idle, data words, optional terminate and one kept gap, idle
  task automatic cmp(input int n, input int base, input int brk);
    logic [71:0] e[$];
    e = {IDL};
    for (int i = 0; i < n; i++)
    begin
      e.push_back(72'(i + base));
      if (i == brk)
        e = {e, TRM, IDL};
    end
    e.push_back(IDL);
    chk(q.size(), e.size());
    foreach (e[i])
      chk(q[i], e[i]);
  endtask

  // main sequence
  initial
  begin
    {rst, psel, pen, pwr, sd, lock, txv, stall, go} = 9'h100;
    pa = 8'h00;
    pwd = 32'h0;
    txw = '0;
    gow = '0;
    last = '0;
    cyc = 0;
    vcnt = 0;
    tick(16);
    rst <= 1'b0;
    tick(3);
    chk({txc, txd}, LFW);
    foreach (rrow[i])
    begin
      rd(rrow[i][39:32], rrow[i][31:0]);
      chk(rerr, rrow[i][40]);
    end
    foreach (sdr[i])
    begin
      apb(1'b1, `USX_OFS_SD_CFG, {30'h0, sdr[i][4], sdr[i][3]});
      sd <= sdr[i][2];
      tick(4);
      @(negedge clk);
      chk(aneg, sdr[i][1]);
      @(posedge clk);
      rd(`USX_OFS_LOCK_STAT, {30'h0, sdr[i][0], 1'b0});
    end
    rd(`USX_OFS_IRQ_STAT, 32'h1);
    foreach (irw[i])
    begin
      apb(1'b1, irw[i][12:5], {28'h0, irw[i][4:1]});
      tick(3);
      @(negedge clk);
      chk(irq, irw[i][0]);
      @(posedge clk);
    end
    lock <= 1'b1;
    tick(3);
    rd(`USX_OFS_LOCK_STAT, 32'h3);
    lock <= 1'b0;
    tick(3);
    rd(`USX_OFS_LOCK_STAT, 32'h2);
    chk({txc, txd}, LFW);
    apb(1'b1, `USX_OFS_RADAPT_CFG, 32'h108041);
    tick(4);
    chk({txc, txd}, IDL);
    apb(1'b1, `USX_OFS_RADAPT_CFG, 32'h8041);
    lock <= 1'b1;
    // one sampled word per replication group at every speed
    for (int s = 0; s < 6; s++)
    begin
      apb(1'b1, `USX_OFS_SPEED, 32'(s));
      vcnt = 0;
      for (int i = 0; i < 2 * grp[s]; i++)
        rxs(72'(i));
      go <= 1'b0;
      tick(3);
      chk(vcnt, 2);
      chk(rxd, 64'(grp[s]));
    end
    apb(1'b1, `USX_OFS_SPEED, 32'(SPD_2G5));
    for (int d = 0; d < 2; d++)
    begin
      apb(1'b1, `USX_OFS_RST_CTRL, 32'(d));
      foreach (ow[i])
        rxs(ow[i]);
      go <= 1'b0;
      tick(3);
      chk({rxc, rxd}, d ? 72'h2 : LFW);
    end
    // fill with the line stalled: beyond the drop level only one gap survives
    stall <= 1'b1;
    for (int i = 0; i < 9; i++)
      push(72'(i + 16));
    push(TRM);
    repeat (3) push(IDL);
    for (int i = 9; i < 13; i++)
      push(72'(i + 16));
    @(negedge clk);
    chk(txr, 1'b0);
    @(posedge clk);
    apb(1'b0, `USX_OFS_IRQ_STAT, 32'h0);
    chk(rdat[3], 1'b1);
    q.delete();
    last = '0;
    stall <= 1'b0;
    tick(40);
    cmp(13, 16, 8);
    // below the add level after a gap the line gets idles, not data
    apb(1'b1, `USX_OFS_RADAPT_CFG, 32'h8081);
    stall <= 1'b1;
    push(IDL);
    for (int i = 0; i < 3; i++)
      push(72'(i + 48));
    q.delete();
    last = '0;
    stall <= 1'b0;
    tick(12);
    chk(q.size(), 1);
    for (int i = 3; i < 8; i++)
      push(72'(i + 48));
    tick(30);
    cmp(8, 48, -1);
    apb(1'b0, `USX_OFS_IRQ_STAT, 32'h0);
    chk(rdat[2], 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
